// ==== logic/sleep_fault_pkg.sv ====
package sleep_fault_pkg;

  localparam logic [4:0]  LOWPOWER_CONTROL_OFFSET     = 5'h03;
  localparam logic [4:0]  GLOBAL_FAULT_SUMMARY_OFFSET = 5'h04;
  localparam logic [4:0]  CH1_FAULT_REG_OFFSET        = 5'h0d;
  localparam logic [4:0]  CH2_FAULT_REG_OFFSET        = 5'h16;

  localparam logic [15:0] LOWPOWER_CONTROL_RESET      = 16'hff80;
  localparam logic [15:0] LOWPOWER_CONTROL_WMASK      = 16'h007f;
  localparam logic [15:0] GLOBAL_FAULT_RESET          = 16'h0147;

  localparam int THR_CH2_LSB    = 5;
  localparam int THR_CH1_LSB    = 3;
  localparam int FORCE_CH2_BIT  = 2;
  localparam int FORCE_CH1_BIT  = 1;
  localparam int MAN_REQ_BIT    = 0;

  localparam int CH2_SUM_BIT    = 13;
  localparam int CH1_SUM_BIT    = 12;
  localparam int LIVE_BIT       = 11;
  localparam int OVERLOAD_BIT   = 10;
  localparam int OFFSTATE_BIT   = 9;
  localparam int STICKY_BIT     = 5;

  // Threshold codes, in milliamps.
  localparam logic [9:0] THR_CODE0_MA = 10'd530;
  localparam logic [9:0] THR_CODE1_MA = 10'd700;
  localparam logic [9:0] THR_CODE2_MA = 10'd165;
  localparam logic [9:0] THR_CODE3_MA = 10'd350;

  typedef enum logic [2:0] {
    ST_ACTIVE = 3'b001,
    ST_MANUAL = 3'b010,
    ST_AUTO   = 3'b100
  } sleep_state_t;

endpackage

// ==== logic/wake_threshold_decode.sv ====
module wake_threshold_decode
  import sleep_fault_pkg::*;
(
  input  wire logic [1:0] code_i,
  output logic      [9:0] threshold_ma_o
);
  always_comb begin
    case (code_i)
      2'd0:    threshold_ma_o = THR_CODE0_MA;
      2'd1:    threshold_ma_o = THR_CODE1_MA;
      2'd2:    threshold_ma_o = THR_CODE2_MA;
      default: threshold_ma_o = THR_CODE3_MA;
    endcase
  end
endmodule // wake_threshold_decode

// ==== logic/fault_summary_bit.sv ====
module fault_summary_bit (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic cond_i,
  input  wire logic clear_read_i,
  input  wire logic latch_disable_i,
  output logic      flag_o
);
  logic flag_reg;
  logic flag_next;

  // The live condition wins over a read, so no fault is lost.
  always_comb begin
    if (latch_disable_i) begin
      flag_next = cond_i;
    end else if (cond_i) begin
      flag_next = 1'b1;
    end else if (clear_read_i) begin
      flag_next = 1'b0;
    end else begin
      flag_next = flag_reg;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag_o = flag_reg;
endmodule // fault_summary_bit

// ==== logic/lowpower_fault_regs.sv ====
// How it works
// - Channel-two wake threshold field, bits 6-5.
// - Channel-one wake threshold field, bits 4-3.
// - Force bit two exits auto sleep, enables channel.
// - Force bit one exits auto sleep, enables channel.
// - Force bits held block automatic sleep re-entry.
// - Manual request enters sleep only when conditions hold.
// - Clearing request checks force bits, enables channels.
// - Clearing request in manual sleep returns active.
// - Current wake needs request rewritten zero then one.
// - Channel-two summary latches until read and clear.
// - Channel-one summary latches until read and clear.
// - Latch disable makes summaries follow conditions, except the off-state summary.
// - Live sleep bit follows either sleep state.
// - Overload summary set by either channel's overload.
// - Off-state summary set by shorts or open load.
// - Sticky sleep flag clears on read when awake.
// - Auto sleep exits on current above auto threshold.
module lowpower_fault_regs
  import sleep_fault_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        wr_en_i,
  input  wire logic        rd_en_i,
  input  wire logic [4:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        fault_latch_disable_i,
  input  wire logic        ch1_on_i,
  input  wire logic        ch2_on_i,
  input  wire logic [9:0]  ch1_current_ma_i,
  input  wire logic [9:0]  ch2_current_ma_i,
  input  wire logic        auto_sleep_ok_i,
  input  wire logic        auto_wake_current_i,
  input  wire logic        ch1_fault_i,
  input  wire logic        ch2_fault_i,
  input  wire logic        ch1_overload_i,
  input  wire logic        ch2_overload_i,
  input  wire logic        ch1_offstate_i,
  input  wire logic        ch2_offstate_i,
  output logic      [15:0] rdata_o,
  output logic             ch1_enable_req_o,
  output logic             ch2_enable_req_o,
  output logic             manual_sleep_state_o,
  output logic             automatic_sleep_state_o
);

  logic [6:0]   ctrl_reg;
  logic [6:0]   ctrl_next;
  sleep_state_t state_reg;
  sleep_state_t state_next;
  logic         rearm_reg;
  logic         rearm_next;
  logic         sticky_reg;
  logic         sticky_next;
  logic [15:0]  rdata_reg;
  logic [15:0]  rdata_next;
  logic         en1_reg;
  logic         en1_next;
  logic         en2_reg;
  logic         en2_next;
  logic         man_reg;
  logic         man_next;
  logic         auto_reg;
  logic         auto_next;

  logic [9:0]   thr1_ma;
  logic [9:0]   thr2_ma;
  logic         ch1_sum;
  logic         ch2_sum;
  logic         ovl_sum;
  logic         off_sum;

  logic wr_ctrl;
  logic rd_global;
  logic rd_ch1;
  logic rd_ch2;
  logic force_any;
  logic below_thr;
  logic above_thr;
  logic req_set;
  logic req_clear;
  logic entry_reject;
  logic auto_entry;

  // One address compare serves the strobes and the read mux alike.
  function automatic logic reg_hit(input logic [4:0] addr, input logic [4:0] offset);
    return addr == offset;
  endfunction

  assign wr_ctrl   = wr_en_i && reg_hit(addr_i, LOWPOWER_CONTROL_OFFSET);
  assign rd_global = rd_en_i && reg_hit(addr_i, GLOBAL_FAULT_SUMMARY_OFFSET);
  assign rd_ch1    = rd_en_i && reg_hit(addr_i, CH1_FAULT_REG_OFFSET);
  assign rd_ch2    = rd_en_i && reg_hit(addr_i, CH2_FAULT_REG_OFFSET);

  wake_threshold_decode u_thr2 (
    .code_i         (ctrl_reg[THR_CH2_LSB +: 2]),
    .threshold_ma_o (thr2_ma)
  );

  wake_threshold_decode u_thr1 (
    .code_i         (ctrl_reg[THR_CH1_LSB +: 2]),
    .threshold_ma_o (thr1_ma)
  );

  assign force_any = ctrl_reg[FORCE_CH1_BIT] | ctrl_reg[FORCE_CH2_BIT];
  // Off channels count as below threshold.
  assign below_thr = (!ch1_on_i || (ch1_current_ma_i < thr1_ma)) &&
                     (!ch2_on_i || (ch2_current_ma_i < thr2_ma));
  assign above_thr = (ch1_on_i && (ch1_current_ma_i > thr1_ma)) ||
                     (ch2_on_i && (ch2_current_ma_i > thr2_ma));
  assign req_set   = wr_ctrl && wdata_i[MAN_REQ_BIT] && !ctrl_reg[MAN_REQ_BIT];
  assign req_clear = wr_ctrl && !wdata_i[MAN_REQ_BIT];
  // A pending manual request outranks automatic entry.
  assign auto_entry = auto_sleep_ok_i && !force_any && !ctrl_reg[MAN_REQ_BIT];

  // Only the low seven bits are writable.
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = wdata_i[6:0] & LOWPOWER_CONTROL_WMASK[6:0];
    end
  end

  always_comb begin
    state_next   = state_reg;
    rearm_next   = rearm_reg;
    entry_reject = 1'b0;
    if (req_clear) begin
      rearm_next = 1'b1;
    end
    case (state_reg)
      ST_ACTIVE: begin
        if (req_set || (wr_ctrl && wdata_i[MAN_REQ_BIT] && rearm_reg)) begin
          if (rearm_reg && below_thr) begin
            state_next = ST_MANUAL;
          end else begin
            entry_reject = 1'b1;
          end
        end else if (auto_entry) begin
          state_next = ST_AUTO;
        end
      end
      ST_MANUAL: begin
        if (req_clear) begin
          state_next = ST_ACTIVE;
        end else if (above_thr) begin
          state_next = ST_ACTIVE;
          rearm_next = 1'b0;
        end
      end
      ST_AUTO: begin
        if (force_any || auto_wake_current_i) begin
          state_next = ST_ACTIVE;
        end else if (req_set && below_thr) begin
          state_next = ST_MANUAL;
        end
      end
      default: begin
        state_next = ST_ACTIVE;
      end
    endcase
  end

  // Channel enable requests follow the force bits on a force exit from auto sleep or a clearing exit from manual sleep.
  always_comb begin
    en1_next = 1'b0;
    en2_next = 1'b0;
    if ((state_reg == ST_AUTO) && force_any) begin
      en1_next = ctrl_reg[FORCE_CH1_BIT] && !ch1_on_i;
      en2_next = ctrl_reg[FORCE_CH2_BIT] && !ch2_on_i;
    end else if ((state_reg == ST_MANUAL) && req_clear) begin
      // The clearing write carries its own force bits, so those decide.
      en1_next = ctrl_next[FORCE_CH1_BIT] && !ch1_on_i;
      en2_next = ctrl_next[FORCE_CH2_BIT] && !ch2_on_i;
    end
    man_next  = (state_next == ST_MANUAL);
    auto_next = (state_next == ST_AUTO);
  end

  // Entry or a rejected request sets the flag; setting wins over the read.
  always_comb begin
    if ((state_next != ST_ACTIVE) || entry_reject) begin
      sticky_next = 1'b1;
    end else if (rd_global && (state_reg == ST_ACTIVE)) begin
      sticky_next = 1'b0;
    end else begin
      sticky_next = sticky_reg;
    end
  end

  fault_summary_bit u_ch2 (
    .ref_clk_i       (ref_clk_i),
    .rst_i           (rst_i),
    .cond_i          (ch2_fault_i),
    .clear_read_i    (rd_ch2),
    .latch_disable_i (fault_latch_disable_i),
    .flag_o          (ch2_sum)
  );

  fault_summary_bit u_ch1 (
    .ref_clk_i       (ref_clk_i),
    .rst_i           (rst_i),
    .cond_i          (ch1_fault_i),
    .clear_read_i    (rd_ch1),
    .latch_disable_i (fault_latch_disable_i),
    .flag_o          (ch1_sum)
  );

  fault_summary_bit u_ovl (
    .ref_clk_i       (ref_clk_i),
    .rst_i           (rst_i),
    .cond_i          (ch1_overload_i | ch2_overload_i),
    .clear_read_i    (rd_ch1 | rd_ch2),
    .latch_disable_i (fault_latch_disable_i),
    .flag_o          (ovl_sum)
  );

  // Off-state summary latches regardless of the disable setting.
  fault_summary_bit u_off (
    .ref_clk_i       (ref_clk_i),
    .rst_i           (rst_i),
    .cond_i          (ch1_offstate_i | ch2_offstate_i),
    .clear_read_i    (rd_ch1 | rd_ch2),
    .latch_disable_i (1'b0),
    .flag_o          (off_sum)
  );

  // Reads return registered data one cycle after the strobe.
  always_comb begin
    rdata_next = rdata_reg;
    if (rd_en_i) begin
      rdata_next = 16'h0000;
      if (reg_hit(addr_i, LOWPOWER_CONTROL_OFFSET)) begin
        rdata_next = {LOWPOWER_CONTROL_RESET[15:7], ctrl_reg};
      end else if (reg_hit(addr_i, GLOBAL_FAULT_SUMMARY_OFFSET)) begin
        rdata_next = GLOBAL_FAULT_RESET;
        rdata_next[CH2_SUM_BIT]  = ch2_sum;
        rdata_next[CH1_SUM_BIT]  = ch1_sum;
        rdata_next[LIVE_BIT]     = (state_reg != ST_ACTIVE);
        rdata_next[OVERLOAD_BIT] = ovl_sum;
        rdata_next[OFFSTATE_BIT] = off_sum;
        rdata_next[STICKY_BIT]   = sticky_reg;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl_reg <= LOWPOWER_CONTROL_RESET[6:0];
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Armed out of reset, so the first request needs no clearing write.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_reg <= ST_ACTIVE;
      rearm_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      rearm_reg <= rearm_next;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      en1_reg  <= 1'b0;
      en2_reg  <= 1'b0;
      man_reg  <= 1'b0;
      auto_reg <= 1'b0;
    end else begin
      en1_reg  <= en1_next;
      en2_reg  <= en2_next;
      man_reg  <= man_next;
      auto_reg <= auto_next;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sticky_reg <= GLOBAL_FAULT_RESET[STICKY_BIT];
    end else begin
      sticky_reg <= sticky_next;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o                 = rdata_reg;
  assign ch1_enable_req_o        = en1_reg;
  assign ch2_enable_req_o        = en2_reg;
  assign manual_sleep_state_o    = man_reg;
  assign automatic_sleep_state_o = auto_reg;

endmodule // lowpower_fault_regs

// ==== testbench/sleep_fault_sva.sv ====
module sleep_fault_sva (
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic        wr_en_i,
  input wire logic        rd_en_i,
  input wire logic [4:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        ch1_on_i,
  input wire logic        ch2_on_i,
  input wire logic        auto_wake_current_i,
  input wire logic [15:0] rdata_o,
  input wire logic        ch1_enable_req_o,
  input wire logic        ch2_enable_req_o,
  input wire logic        manual_sleep_state_o,
  input wire logic        automatic_sleep_state_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] ctl_reg;
  logic [2:0] ctl_next;
  logic       wr_ctl;
  logic       man;
  logic       aut;
  assign wr_ctl = wr_en_i && (addr_i == 5'h03);
  assign man = manual_sleep_state_o;
  assign aut = automatic_sleep_state_o;
  always_comb begin
    ctl_next = wr_ctl ? wdata_i[2:0] : ctl_reg;
  end
  always_ff @(posedge ref_clk_i) begin
    ctl_reg <= rst_i ? 3'h0 : ctl_next;
  end
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  // A force written in auto sleep takes effect one cycle after the write lands.
  sequence s_force2;
    aut && wr_ctl && wdata_i[2] && !wdata_i[0] && !ch2_on_i && ctl_reg[2:1] == 2'b00
      && !auto_wake_current_i;
  endsequence
  sequence s_woke2;
    !aut && ch2_enable_req_o;
  endsequence
  // Only a fresh request counts, since a stale one after a current wake is refused.
  a_fresh_entry: assert property (wr_ctl && wdata_i[2:0] == 3'h1 && !ctl_reg[0] && !man
    && !aut && !ch1_on_i && !ch2_on_i |=> man) else $error("entry missed");
  a_manual_exit: assert property (man && wr_ctl && !wdata_i[0] |=> !man)
    else $error("exit missed");
  a_force_wake: assert property (s_force2 |-> ##2 s_woke2) else $error("force missed");
  a_manual_force: assert property (man && wr_ctl && wdata_i[1:0] == 2'b10 && !ch1_on_i
    |=> ch1_enable_req_o) else $error("manual force missed");
  a_auto_held: assert property (ctl_reg[2:1] != 2'b00 && !aut |=> !aut)
    else $error("auto while forced");
  a_auto_wake: assert property (aut && auto_wake_current_i |-> ##[1:2] !aut)
    else $error("auto wake missed");
  a_live_bit: assert property (rd_en_i && addr_i == 5'h04 |=> rdata_o[11] == $past(man || aut))
    else $error("live bit");
  a_ctl_reserved: assert property (rd_en_i && addr_i == 5'h03 |=> rdata_o[15:7] == 9'h1ff)
    else $error("ctl reserved");
  a_sum_reserved: assert property (rd_en_i && addr_i == 5'h04 |=> rdata_o[15:14] == 2'b00)
    else $error("sum reserved");
endmodule // sleep_fault_sva

bind lowpower_fault_regs sleep_fault_sva u_sva (.ref_clk_i, .rst_i, .wr_en_i, .rd_en_i,
  .addr_i, .wdata_i, .ch1_on_i, .ch2_on_i, .auto_wake_current_i, .rdata_o,
  .ch1_enable_req_o, .ch2_enable_req_o, .manual_sleep_state_o, .automatic_sleep_state_o);

// ==== testbench/spi_host_model.sv ====
module spi_host_model (
  input  wire logic        ref_clk_i,
  input  wire logic [15:0] rdata_i,
  output logic             wr_en_o,
  output logic             rd_en_o,
  output logic      [4:0]  addr_o,
  output logic      [15:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = 5'h00;
    wdata_o = 16'h0000;
  end
  // Released lines show the inverse, so a stale word can never pass for a fresh one.
  // Re-arming sleep is the host's duty: request written 0, then 1.
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [15:0] d,
                      output logic [15:0] q);
    @(negedge ref_clk_i);
    wr_en_o = wr;
    rd_en_o = !wr;
    addr_o = a;
    wdata_o = d;
    @(negedge ref_clk_i);
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
    q = rdata_i;
  endtask
endmodule // spi_host_model

// ==== testbench/lowpower_fault_regs_bench.sv ====
module lowpower_fault_regs_bench
  import sleep_fault_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [4:0] LC = LOWPOWER_CONTROL_OFFSET;
  localparam logic [4:0] GF = GLOBAL_FAULT_SUMMARY_OFFSET;
  logic        ref_clk_i;
  logic        rst_i;
  logic        wr_en_i;
  logic        rd_en_i;
  logic [4:0]  addr_i;
  logic [15:0] wdata_i;
  logic        fault_latch_disable_i;
  logic [1:0]  on;
  logic [9:0]  cur1;
  logic [9:0]  cur2;
  logic        aok;
  logic        awk;
  logic [5:0]  flt;
  logic [15:0] rdata_o;
  logic [1:0]  en;
  logic        man;
  logic        aut;
  logic [15:0] q;
  logic [15:0] m;
  logic [15:0] f;
  logic [9:0]  thr [4];
  int          fbit [6];
  int          pls [2];
  int          bad_count = 0;
  int          total_checks = 0;
  lowpower_fault_regs dut (.ref_clk_i, .rst_i, .wr_en_i, .rd_en_i, .addr_i, .wdata_i,
    .fault_latch_disable_i, .ch1_on_i(on[0]), .ch2_on_i(on[1]), .ch1_current_ma_i(cur1),
    .ch2_current_ma_i(cur2), .auto_sleep_ok_i(aok), .auto_wake_current_i(awk),
    .ch1_fault_i(flt[0]), .ch2_fault_i(flt[1]), .ch1_overload_i(flt[2]),
    .ch2_overload_i(flt[3]), .ch1_offstate_i(flt[4]), .ch2_offstate_i(flt[5]), .rdata_o,
    .ch1_enable_req_o(en[0]), .ch2_enable_req_o(en[1]), .manual_sleep_state_o(man),
    .automatic_sleep_state_o(aut));
  spi_host_model host (.ref_clk_i, .rdata_i(rdata_o), .wr_en_o(wr_en_i), .rd_en_o(rd_en_i),
    .addr_o(addr_i), .wdata_o(wdata_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    pls[0] = pls[0] + int'(en[0] === 1'b1);
    pls[1] = pls[1] + int'(en[1] === 1'b1);
  end
  task automatic complete_run();
    if (bad_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic c(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask
  task automatic w(input logic [4:0] a, input logic [15:0] d);
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic r(input logic [4:0] a);
    host.xfer(1'b0, a, 16'h0000, q);
  endtask
  // Bounded wait for {manual, auto}; a state that never arrives ends the run.
  task automatic s(input logic [1:0] e);
    for (int i = 0; i < 8 && {man, aut} !== e; i++)
      @(negedge ref_clk_i);
    c("sleep_state", {14'h0000, e}, {14'h0000, man, aut});
    if ({man, aut} !== e)
      complete_run();
  endtask
  task automatic t_regs();
    r(LC);
    c("ctl_reset", LOWPOWER_CONTROL_RESET, q);
    w(LC, 16'h0078);
    w(GF, 16'hffff);
    r(LC);
    c("ctl_fields", 16'hfff8, q);
    r(GF);
    c("sum_idle", 16'h0000, q & 16'hfe20);
    r(5'h1f);
    c("unmapped", 16'h0000, q);
  endtask
  task automatic t_thr();
    on = 2'b11;
    for (int k = 0; k < 4; k++) begin
      f = {9'h000, k[1:0], k[1:0], 3'b000};
      cur1 = thr[k] - 10'd1;
      cur2 = thr[k] - 10'd1;
      w(LC, f);
      w(LC, f | 16'h0001);
      s(2'b10);
      cur2 = thr[k] + 10'd1;
      s(2'b00);
      cur2 = thr[k] - 10'd1;
      w(LC, f | 16'h0001);
      s(2'b00);
      w(LC, f);
      w(LC, f | 16'h0001);
      s(2'b10);
      w(LC, f);
      s(2'b00);
      w(LC, f | 16'h0001);
      s(2'b10);
      cur1 = thr[k] + 10'd1;
      s(2'b00);
      w(LC, f);
    end
  endtask
  task automatic t_flags();
    r(GF);
    on = 2'b01;
    cur1 = THR_CODE0_MA + 10'd70;
    w(LC, 16'h0001);
    s(2'b00);
    w(LC, 16'h0000);
    r(GF);
    c("sticky_reject", 16'h0020, q & 16'h0820);
    r(GF);
    c("sticky_clear", 16'h0000, q & 16'h0820);
    on = 2'b00;
    w(LC, 16'h0001);
    s(2'b10);
    r(GF);
    r(GF);
    c("asleep_flags", 16'h0820, q & 16'h0820);
    w(LC, 16'h0000);
    s(2'b00);
    r(GF);
    c("awake_flags", 16'h0020, q & 16'h0820);
  endtask
  task automatic t_auto();
    pls = '{0, 0};
    aok = 1'b1;
    s(2'b01);
    w(LC, 16'h0004);
    s(2'b00);
    r(GF);
    s(2'b00);
    w(LC, 16'h0000);
    s(2'b01);
    awk = 1'b1;
    s(2'b00);
    awk = 1'b0;
    s(2'b01);
    w(LC, 16'h0002);
    s(2'b00);
    aok = 1'b0;
    w(LC, 16'h0001);
    s(2'b10);
    w(LC, 16'h0006);
    s(2'b00);
    r(GF);
    c("wake_pulses", 16'h0202, {8'(pls[1]), 8'(pls[0])});
    w(LC, 16'h0000);
  endtask
  // Latched when k < 6, following the condition afterwards.
  task automatic t_fault();
    for (int k = 0; k < 10; k++) begin
      m = 16'h0001 << fbit[k % 6];
      fault_latch_disable_i = (k >= 6);
      flt[k % 6] = 1'b1;
      @(negedge ref_clk_i);
      r(GF);
      c("sum_set", m, q & m);
      flt[k % 6] = 1'b0;
      r(GF);
      c("sum_after", (k < 6) ? m : 16'h0000, q & m);
      r((k % 2) ? CH2_FAULT_REG_OFFSET : CH1_FAULT_REG_OFFSET);
      r(GF);
      c("sum_clear", 16'h0000, q & m);
    end
  endtask
  initial begin
    thr = '{THR_CODE0_MA, THR_CODE1_MA, THR_CODE2_MA, THR_CODE3_MA};
    fbit = '{CH1_SUM_BIT, CH2_SUM_BIT, OVERLOAD_BIT, OVERLOAD_BIT, OFFSTATE_BIT, OFFSTATE_BIT};
    pls = '{0, 0};
    rst_i = 1'b1;
    fault_latch_disable_i = 1'b0;
    on = 2'b00;
    cur1 = 10'h000;
    cur2 = 10'h000;
    aok = 1'b0;
    awk = 1'b0;
    flt = 6'h00;
    repeat (3) @(negedge ref_clk_i);
    rst_i = 1'b0;
    t_regs();
    t_thr();
    t_flags();
    t_auto();
    t_fault();
    complete_run();
  end
endmodule // lowpower_fault_regs_bench
